// file: fwp_defs.vh
// constants for the flash write-protection block
`ifndef FWP_DEFS_VH
`define FWP_DEFS_VH

// register word addresses on the plain register port
`define FWP_REG_STATUS   4'h0
`define FWP_REG_PROT     4'h1
`define FWP_REG_ADDR     4'h2
`define FWP_REG_DATA     4'h3
`define FWP_REG_PWD_LO   4'h4
`define FWP_REG_PWD_HI   4'h5
`define FWP_REG_CMD      4'h6
`define FWP_REG_UNIT     4'h7

// status register fields
`define FWP_ST_WEL       0
`define FWP_ST_BP_LSB    1
`define FWP_ST_BP_MSB    4
`define FWP_ST_QE        5
`define FWP_ST_SWD       6

// protection state register fields
`define FWP_PR_LOCK      0
`define FWP_PR_PWDMODE   1
`define FWP_PR_LOC       2
`define FWP_PR_REFUSED   3
`define FWP_PR_PROT      4

// unit word fields
`define FWP_UN_PPB       0
`define FWP_UN_DYB       1
`define FWP_UN_PROT      2
`define FWP_UN_IDX_LSB   3
`define FWP_UN_IDX_MSB   12

// command codes written to the command register
`define FWP_CMD_WRITE_ENABLE_INSTRUCTION     4'h1
`define FWP_CMD_WRDI     4'h2
`define FWP_CMD_PPB_PGM  4'h3
`define FWP_CMD_PPB_ERS  4'h4
`define FWP_CMD_DYB_WR   4'h5
`define FWP_CMD_LOCK_CLR 4'h6
`define FWP_CMD_UNLOCK   4'h7
`define FWP_CMD_PWD_PGM  4'h8
`define FWP_CMD_PWD_SEL  4'h9
`define FWP_CMD_LOC_TOP  4'ha
`define FWP_CMD_ARRAY    4'hb

// protection unit layout
`define FWP_UNITS        542
`define FWP_SMALL_BLKS   9'h002
`define FWP_TOP_BLK      9'h1fe
`define FWP_TOP_UNIT     10'h1fe
`define FWP_BLK_OFFSET   10'h01e
`define FWP_BP_ALL       4'ha
`define FWP_ARRAY_BLKS   10'h200

// reset and factory values
`define FWP_PWD_FACTORY  64'hffffffffffffffff

`endif

// file: fwp_protect.v
// write-protection logic of a serial flash: pins, bits, lock, password
//
// Behaviour
// R1 - swd and low pin lock status bits
// R2 - no write enable latch, command ignored
// R3 - protected if either scheme protects
// R4 - host uses only one scheme
// R5 - persistent or dynamic bit zero blocks unit
// R6 - lock bit zero refuses persistent changes
// R7 - persistent bits start erased, unprotected
// R8 - persistent mode: lock set after reset
// R9 - lock-clear command clears lock bit
// R10 - persistent mode: nothing sets lock again
// R11 - password mode: lock cleared after reset
// R12 - hidden permanent 64-bit password
// R13 - matching password unlock sets lock bit
// R14 - unlock repeatable after lock cleared
// R15 - otp bit chooses lock management mode
// R16 - 542 units: 32 sectors, 510 blocks
// R17 - bottom layout: units 0..31 small sectors
// R18 - location 0 top, 1 bottom
// R19 - program one persistent bit, erase all
// R20 - dynamic bits volatile, freely changed
// R21 - protected target leaves array unchanged
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/1ns
`include "fwp_defs.vh"

module fwp_protect (
  input  wire        clk,          // device clock
  input  wire        reset_n,      // hardware reset, active low
  input  wire        wp_n,         // write-protect pin, active low
  input  wire        factory_init, // puts non-volatile cells in shipped state
  input  wire [3:0]  addr,         // register word address
  input  wire [31:0] wdata,        // register write data
  input  wire        wr,           // register write strobe
  input  wire        rd,           // register read strobe
  output reg  [31:0] rdata,        // read data, cycle after rd
  output reg         array_go,     // pulse: array program/erase may run
  output reg         array_block   // pulse: array command refused
);

  // write-protect pin synchroniser
  reg         wp_meta;
  reg         wp_sync;

  // volatile control state
  reg         write_enable_latch;
  reg         swd;
  reg         qe;
  reg  [3:0]  bp;
  reg         lock;
  reg         init_done;
  reg         last_refused;
  reg         last_prot;
  reg  [24:0] op_addr;
  reg         dyb_val;
  reg  [63:0] pwd_in;

  // non-volatile cells, untouched by reset
  reg  [63:0] pwd_store;
  reg         pwd_mode;
  reg         loc;
  reg  [`FWP_UNITS-1:0] persistent_protection_bit;

  // volatile per-unit bits
  reg  [`FWP_UNITS-1:0] dynamic_protection_bit;

  // command decode
  wire        cmd_go;
  wire [3:0]  code;
  reg         need_wel;
  reg         cmd_ok;
  wire        st_go;
  wire        st_ok;
  wire        st_take;
  wire        cmd_take;
  wire        arr_cmd;

  // unit and protection lookup
  wire [8:0]  blk;
  wire [4:0]  sect;
  wire [9:0]  unit;
  wire [9:0]  bp_base;
  wire        prot_bp;
  wire        prot_asp;
  wire        prot;
  wire [9:0]  unit_bot;
  wire [9:0]  unit_top;

  // register read words
  reg  [31:0] status_word;
  reg  [31:0] prot_word;
  reg  [31:0] unit_word;

  // two flops before the pin is looked at
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wp_meta <= 1'b1;
      wp_sync <= 1'b1;
    end else begin
      wp_meta <= wp_n;
      wp_sync <= wp_meta;
    end
  end

  // address to protection unit
  assign blk  = op_addr[24:16];
  assign sect = op_addr[16:12];

  // bottom layout: small sectors first, blocks moved up past them
  assign unit_bot = (blk < `FWP_SMALL_BLKS) ? {5'h00, sect}  // R17
                    : ({1'b0, blk} + `FWP_BLK_OFFSET);       // R16

  // top layout: blocks in order, small sectors take the last units
  assign unit_top = (blk < `FWP_TOP_BLK) ? {1'b0, blk}
                    : (`FWP_TOP_UNIT + {5'h00, sect});       // R16
  assign unit     = loc ? unit_bot : unit_top;               // R18

  // block-protect bits guard the top 2^(bp-1) blocks
  assign bp_base = `FWP_ARRAY_BLKS - (10'h001 << (bp - 4'h1));
  assign prot_bp = (bp != 4'h0) &&
                   ((bp >= `FWP_BP_ALL) || ({1'b0, blk} >= bp_base));

  // either per-unit bit at zero protects
  assign prot_asp = ~persistent_protection_bit[unit] | ~dynamic_protection_bit[unit];                 // R5
  assign prot     = prot_bp | prot_asp;                      // R3

  // strobes decoded from the register port
  assign cmd_go = wr && (addr == `FWP_REG_CMD);
  assign code   = wdata[3:0];
  assign st_go  = wr && (addr == `FWP_REG_STATUS);
  assign st_ok  = write_enable_latch && !(swd && !wp_sync);                 // R1 R2
  assign st_take  = st_go && st_ok;                          // R1 R2
  assign cmd_take = cmd_go && cmd_ok;
  assign arr_cmd  = cmd_go && (code == `FWP_CMD_ARRAY);

  // which commands need the latch and which may run
  always @* begin
    need_wel = 1'b1;
    cmd_ok   = 1'b0;
    case (code)
      `FWP_CMD_WRITE_ENABLE_INSTRUCTION: begin
        need_wel = 1'b0;
        cmd_ok   = 1'b1;
      end
      `FWP_CMD_WRDI: begin
        need_wel = 1'b0;
        cmd_ok   = 1'b1;
      end
      `FWP_CMD_UNLOCK: begin
        need_wel = 1'b0;
        cmd_ok   = pwd_mode && (pwd_in == pwd_store);        // R13 R14
      end
      `FWP_CMD_PPB_PGM: cmd_ok = write_enable_latch && lock;                // R6 R2
      `FWP_CMD_PPB_ERS: cmd_ok = write_enable_latch && lock;                // R6 R2
      `FWP_CMD_DYB_WR:  cmd_ok = write_enable_latch;                        // R2
      `FWP_CMD_LOCK_CLR: cmd_ok = write_enable_latch;                       // R2
      `FWP_CMD_PWD_PGM: cmd_ok = write_enable_latch && !pwd_mode;           // R12
      `FWP_CMD_PWD_SEL: cmd_ok = write_enable_latch;                        // R15
      `FWP_CMD_LOC_TOP: cmd_ok = write_enable_latch;                        // R2
      `FWP_CMD_ARRAY:   cmd_ok = write_enable_latch && !prot;               // R21
      default: begin
        need_wel = 1'b0;
        cmd_ok   = 1'b0;
      end
    endcase
  end

  // array command outcome as one-cycle pulses
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      array_go    <= 1'b0;
      array_block <= 1'b0;
    end else begin
      array_go    <= arr_cmd && cmd_ok;                      // R21
      array_block <= arr_cmd && !cmd_ok;                     // R2 R21
    end
  end

  // write enable latch: set by its command, spent by an accepted status write or accepted command that needs the latch
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      write_enable_latch <= 1'b0;
    else if (cmd_go && code == `FWP_CMD_WRITE_ENABLE_INSTRUCTION)
      write_enable_latch <= 1'b1;
    else if (cmd_go && code == `FWP_CMD_WRDI)
      write_enable_latch <= 1'b0;
    else if (st_take)
      write_enable_latch <= 1'b0;                                           // R2
    else if (cmd_take && need_wel)
      write_enable_latch <= 1'b0;                                           // R2
  end

  // status bits, changed only when latch and pin allow it
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      swd <= 1'b0;
      qe  <= 1'b0;
      bp  <= 4'h0;
    end else if (st_take) begin
      bp  <= wdata[`FWP_ST_BP_MSB:`FWP_ST_BP_LSB];           // R1
      qe  <= wdata[`FWP_ST_QE];                              // R1
      swd <= wdata[`FWP_ST_SWD];                             // R1
    end
  end

  // outcome of the last status write or command, for software
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      last_refused <= 1'b0;
      last_prot    <= 1'b0;
    end else if (st_go) begin
      last_refused <= !st_ok;
    end else if (cmd_go) begin
      last_refused <= !cmd_ok;
      if (code == `FWP_CMD_ARRAY)
        last_prot <= prot;                                   // R3
    end
  end

  // lock bit: caught from the mode one cycle after release
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      init_done <= 1'b0;
      lock      <= 1'b1;
    end else if (!init_done) begin
      init_done <= 1'b1;
      lock      <= ~pwd_mode;                                // R8 R11
    end else if (cmd_go && cmd_ok) begin
      if (code == `FWP_CMD_LOCK_CLR)
        lock <= 1'b0;                                        // R9
      else if (code == `FWP_CMD_UNLOCK)
        lock <= 1'b1;                                        // R13 R10
    end
  end

  // operand registers written by software
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      op_addr <= 25'h0000000;
      dyb_val <= 1'b1;
      pwd_in  <= 64'h0000000000000000;
    end else if (wr) begin
      case (addr)
        `FWP_REG_ADDR:   op_addr      <= wdata[24:0];
        `FWP_REG_DATA:   dyb_val      <= wdata[0];
        `FWP_REG_PWD_LO: pwd_in[31:0] <= wdata;
        `FWP_REG_PWD_HI: pwd_in[63:32] <= wdata;
        default:         op_addr      <= op_addr;
      endcase
    end
  end

  // one-time cells: password, mode select, parameter location
  always @(posedge clk) begin
    if (factory_init) begin
      pwd_store <= `FWP_PWD_FACTORY;
      pwd_mode  <= 1'b0;
      loc       <= 1'b1;
    end else if (cmd_go && cmd_ok) begin
      case (code)
        `FWP_CMD_PWD_PGM: pwd_store <= pwd_store & pwd_in;   // R12
        `FWP_CMD_PWD_SEL: pwd_mode  <= 1'b1;                 // R15
        `FWP_CMD_LOC_TOP: loc       <= 1'b0;                 // R18
        default:          loc       <= loc;
      endcase
    end
  end

  // per-unit persistent and dynamic bits
  genvar i;
  generate
    for (i = 0; i < `FWP_UNITS; i = i + 1) begin : g_unit
      // persistent: program singly, erase all together
      always @(posedge clk) begin
        if (factory_init)
          persistent_protection_bit[i] <= 1'b1;                                    // R7
        else if (cmd_go && cmd_ok && code == `FWP_CMD_PPB_ERS)
          persistent_protection_bit[i] <= 1'b1;                                    // R19
        else if (cmd_go && cmd_ok && code == `FWP_CMD_PPB_PGM &&
                 unit == i)
          persistent_protection_bit[i] <= 1'b0;                                    // R19 R6
      end

      // dynamic: volatile, unprotected after reset
      always @(posedge clk or negedge reset_n) begin
        if (!reset_n)
          dynamic_protection_bit[i] <= 1'b1;
        else if (cmd_go && cmd_ok && code == `FWP_CMD_DYB_WR &&
                 unit == i)
          dynamic_protection_bit[i] <= dyb_val;                                 // R20
      end
    end
  endgenerate

  // status word from its fields
  always @* begin
    status_word                                = 32'h00000000;
    status_word[`FWP_ST_WEL]                   = write_enable_latch;
    status_word[`FWP_ST_BP_MSB:`FWP_ST_BP_LSB] = bp;
    status_word[`FWP_ST_QE]                    = qe;
    status_word[`FWP_ST_SWD]                   = swd;
  end

  // protection state word: lock, mode, layout and last outcome
  always @* begin
    prot_word                  = 32'h00000000;
    prot_word[`FWP_PR_LOCK]    = lock;
    prot_word[`FWP_PR_PWDMODE] = pwd_mode;
    prot_word[`FWP_PR_LOC]     = loc;
    prot_word[`FWP_PR_REFUSED] = last_refused;
    prot_word[`FWP_PR_PROT]    = last_prot;
  end

  // unit word: index of the addressed unit and its protection
  always @* begin
    unit_word                                  = 32'h00000000;
    unit_word[`FWP_UN_PPB]                     = persistent_protection_bit[unit];
    unit_word[`FWP_UN_DYB]                     = dynamic_protection_bit[unit];
    unit_word[`FWP_UN_PROT]                    = prot;
    unit_word[`FWP_UN_IDX_MSB:`FWP_UN_IDX_LSB] = unit;
  end

  // read data, one cycle after the strobe
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 32'h00000000;
    end else if (rd) begin
      case (addr)
        `FWP_REG_STATUS:
          rdata <= status_word;
        `FWP_REG_PROT:
          rdata <= prot_word;
        `FWP_REG_ADDR:
          rdata <= {7'h00, op_addr};
        `FWP_REG_DATA:
          rdata <= {31'h00000000, dyb_val};
        `FWP_REG_UNIT:
          rdata <= unit_word;
        default:
          rdata <= 32'h00000000;
      endcase
    end else begin
      rdata <= 32'h00000000;
    end
  end

endmodule // fwp_protect

// file: fwp_protect_chk.sv
// checker for the ports of the flash write-protection block
`timescale 1ns/1ns
`include "fwp_defs.vh"
module fwp_protect_chk (
  input wire        clk,          // device clock
  input wire        reset_n,      // hardware reset
  input wire        wp_n,         // write-protect pin
  input wire        factory_init, // shipped-state load
  input wire [3:0]  addr,         // register address
  input wire [31:0] wdata,        // write data
  input wire        wr,           // write strobe
  input wire        rd,           // read strobe
  input wire [31:0] rdata,        // read data
  input wire        array_go,     // array accepted
  input wire        array_block   // array refused
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // read data only in the cycle after a read
  chk_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("rdata not zero outside read slot");
  // hidden password reads back as zero
  chk_pwd_hidden: assert property (
    rd && addr[3:1] == 3'b010 |=> rdata == 32'h0)
    else $error("password word readable");
  // unmapped addresses read zero
  chk_unmapped_read: assert property (rd && addr[3] |=> rdata == 32'h0)
    else $error("unmapped read not zero");
  // unit index stays inside the unit count
  chk_unit_range: assert property (
    rd && addr == `FWP_REG_UNIT |=> rdata[12:3] < 10'h21e)
    else $error("unit index out of range");
  // accepted array pulse follows an array command
  chk_go_cause: assert property (array_go |->
    $past(wr) && $past(addr) == `FWP_REG_CMD &&
    $past(wdata[3:0]) == `FWP_CMD_ARRAY)
    else $error("array_go without command");
  // refused array pulse follows an array command
  chk_block_cause: assert property (array_block |->
    $past(wr) && $past(addr) == `FWP_REG_CMD &&
    $past(wdata[3:0]) == `FWP_CMD_ARRAY)
    else $error("array_block without command");
  // accept and refuse never together
  chk_pulse_excl: assert property (!(array_go && array_block))
    else $error("array go and block together");
  // accepted array pulse never held two cycles
  chk_go_gap: assert property (array_go |=> !array_go)
    else $error("array_go held two cycles");

  cover property (array_go);
  cover property (array_block);
  cover property (rd && addr == `FWP_REG_PROT);
endmodule // fwp_protect_chk

// file: fwp_host.sv
// host model driving the register port of the protection block
`timescale 1ns/1ns
module fwp_host (
  input  wire        clk,   // device clock
  input  wire [31:0] rdata, // read data
  output reg  [3:0]  addr,  // register address
  output reg  [31:0] wdata, // write data
  output reg         wr,    // write strobe
  output reg         rd     // read strobe
);
  initial begin
    addr = 4'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
  end

  // one-cycle write; data inverted once released
  task wr_reg(input [3:0] a, input [31:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      wdata <= ~d;
    end
  endtask

  // one-cycle read; data taken in the following cycle
  task rd_reg(input [3:0] a, output [31:0] d);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      d = rdata;
    end
  endtask
endmodule // fwp_host

// file: fwp_protect_tb_top.sv
// testbench top for the flash write-protection block
`timescale 1ns/1ns
`include "fwp_defs.vh"
module fwp_protect_tb_top;
  reg         clk;          // device clock
  reg         reset_n;      // hardware reset
  reg         wp_n;         // write-protect pin
  reg         factory_init; // shipped-state load
  wire [3:0]  addr;
  wire [31:0] wdata;
  wire        wr;
  wire        rd;
  wire [31:0] rdata;
  wire        array_go;
  wire        array_block;
  integer     err_count;
  integer     num_checks;
  reg  [31:0] got;

  initial clk = 1'b0;
  always #5 clk = ~clk;

  fwp_protect fwp_protect_inst (.clk(clk), .reset_n(reset_n), .wp_n(wp_n),
    .factory_init(factory_init), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .array_go(array_go), .array_block(array_block));
  fwp_host fwp_host_inst (.clk(clk), .rdata(rdata), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd));

  // compare and report
  task chk(input [3:0] a, input [31:0] e, input [31:0] g);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("Error item %0h exp %h got %h", a, e, g);
      end
    end
  endtask
  task rchk(input [3:0] a, input [31:0] e);
    begin
      fwp_host_inst.rd_reg(a, got);
      chk(a, e, got);
    end
  endtask
  task wreg(input [3:0] a, input [31:0] d);
    fwp_host_inst.wr_reg(a, d);
  endtask
  task cmd(input [3:0] c);
    wreg(`FWP_REG_CMD, {28'h0, c});
  endtask
  task wcmd(input [3:0] c);
    begin
      cmd(`FWP_CMD_WRITE_ENABLE_INSTRUCTION);
      cmd(c);
    end
  endtask
  // array check; e is {block, go}
  task arr(input [1:0] e);
    begin
      wcmd(`FWP_CMD_ARRAY);
      @(posedge clk);
      chk(4'hf, {30'h0, e}, {30'h0, array_block, array_go});
    end
  endtask
  task rst;
    begin
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge clk);
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    err_count = err_count + 1;
    wrap_up;
  end

  // main sequence
  initial begin
    err_count = 0;
    num_checks = 0;
    reset_n = 1'b0;
    wp_n = 1'b1;
    factory_init = 1'b1;
    repeat (10) @(posedge clk);
    factory_init <= 1'b0;
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    rchk(`FWP_REG_PROT, 32'h5);
    rchk(4'h8, 32'h0);
    wreg(`FWP_REG_ADDR, 32'h0);
    rchk(`FWP_REG_UNIT, 32'h3);
    wreg(`FWP_REG_STATUS, 32'h2);
    rchk(`FWP_REG_STATUS, 32'h0);
    cmd(`FWP_CMD_ARRAY);
    @(posedge clk);
    chk(4'he, 32'h2, {30'h0, array_block, array_go});
    cmd(`FWP_CMD_WRITE_ENABLE_INSTRUCTION);
    wreg(`FWP_REG_STATUS, 32'h40);
    rchk(`FWP_REG_STATUS, 32'h40);
    wp_n <= 1'b0;
    cmd(`FWP_CMD_WRITE_ENABLE_INSTRUCTION);
    wreg(`FWP_REG_STATUS, 32'h62);
    rchk(`FWP_REG_STATUS, 32'h41);
    wp_n <= 1'b1;
    repeat (2) @(posedge clk);
    wreg(`FWP_REG_STATUS, 32'h22);
    rchk(`FWP_REG_STATUS, 32'h22);
    wreg(`FWP_REG_ADDR, 32'h1ff0000);
    rchk(`FWP_REG_UNIT, 32'h10ef);
    // block protect back to zero before per-unit work
    cmd(`FWP_CMD_WRITE_ENABLE_INSTRUCTION);
    wreg(`FWP_REG_STATUS, 32'h0);
    wreg(`FWP_REG_ADDR, 32'h30000);
    wreg(`FWP_REG_DATA, 32'h0);
    wcmd(`FWP_CMD_DYB_WR);
    rchk(`FWP_REG_UNIT, 32'h10d);
    arr(2'b10);
    wreg(`FWP_REG_DATA, 32'h1);
    wcmd(`FWP_CMD_DYB_WR);
    arr(2'b01);
    wcmd(`FWP_CMD_PPB_PGM);
    rchk(`FWP_REG_UNIT, 32'h10e);
    wreg(`FWP_REG_ADDR, 32'h1000);
    rchk(`FWP_REG_UNIT, 32'hb);
    wcmd(`FWP_CMD_LOCK_CLR);
    rchk(`FWP_REG_PROT, 32'h4);
    wcmd(`FWP_CMD_PPB_ERS);
    rchk(`FWP_REG_PROT, 32'hc);
    cmd(`FWP_CMD_UNLOCK);
    rchk(`FWP_REG_PROT, 32'hc);
    rst;
    rchk(`FWP_REG_PROT, 32'h5);
    wreg(`FWP_REG_ADDR, 32'h30000);
    rchk(`FWP_REG_UNIT, 32'h10e);
    wcmd(`FWP_CMD_PPB_ERS);
    rchk(`FWP_REG_UNIT, 32'h10b);
    wreg(`FWP_REG_PWD_LO, 32'h1234);
    wreg(`FWP_REG_PWD_HI, 32'h5678);
    wcmd(`FWP_CMD_PWD_PGM);
    wcmd(`FWP_CMD_PWD_SEL);
    rchk(`FWP_REG_PROT, 32'h7);
    rst;
    rchk(`FWP_REG_PROT, 32'h6);
    wreg(`FWP_REG_PWD_LO, 32'h1235);
    cmd(`FWP_CMD_UNLOCK);
    rchk(`FWP_REG_PROT, 32'he);
    rchk(`FWP_REG_PWD_LO, 32'h0);
    wreg(`FWP_REG_PWD_LO, 32'h1234);
    wreg(`FWP_REG_PWD_HI, 32'h5678);
    cmd(`FWP_CMD_UNLOCK);
    rchk(`FWP_REG_PROT, 32'h7);
    wcmd(`FWP_CMD_LOCK_CLR);
    cmd(`FWP_CMD_UNLOCK);
    rchk(`FWP_REG_PROT, 32'h7);
    wcmd(`FWP_CMD_LOC_TOP);
    wreg(`FWP_REG_ADDR, 32'h1ff1000);
    rchk(`FWP_REG_UNIT, 32'h107b);
    rchk(`FWP_REG_PROT, 32'h3);
    wrap_up;
  end
endmodule // fwp_protect_tb_top

bind fwp_protect fwp_protect_chk fwp_protect_chk_inst (.clk(clk),
  .reset_n(reset_n), .wp_n(wp_n), .factory_init(factory_init),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .array_go(array_go), .array_block(array_block));
